/* rtl/rpf_filter.sv */
// Purpose: Receive filter and status register with address match table
// Assumes: Packet summary arrives as one-cycle strobes on clk
// Notes:   Table is searched one entry per cycle after the end strobe
`timescale 1ns/1ps
`default_nettype none
`include "rpf_map.svh"

// Function
// - Upper five bits enable extra filters
// - No filters: only table matches accepted
// - Low nine bits report packet conditions
// - Whole register copied to descriptor word
// - Next packet start clears most status
// - Software reset leaves register alone
// - Error bit governs CRC, collision packets
// - Runt bit accepts short packets
// - Hardware reset clears runt bit
// - Broadcast bit adds broadcast packets
// - Hardware reset clears broadcast bit
// - Promiscuous accepts all individual addresses
// - All-group accepts multicast and broadcast
// - Bits ten, nine select loopback
// - Upper bits writable, status read-only
// - Loopback codes: normal, MAC, coder, transceiver
// - Hardware reset clears loopback bits
// - Multicast and broadcast seen bits
module rpf_filter
   import rpf_pkg::*;
#(
   parameter int DEPTH = `RPF_TABLE_DEPTH,
   parameter int IDX_W = `RPF_TABLE_IDX_W
)(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   soft_reset,
   // Register port
   input  wire logic [`RPF_ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [15:0]            reg_rdata,
   // Address table load
   input  wire logic                   tbl_wr,
   input  wire logic [IDX_W-1:0]       tbl_idx,
   input  wire logic [48:0]            tbl_data,
   // Receive path
   input  wire logic                   pkt_start,
   input  wire logic                   pkt_end,
   input  wire rpf_pkt_type            pkt_info,
   input  wire logic                   carrier_pin,
   // Results
   output logic                        pkt_accept,
   output logic                        pkt_reject,
   output logic      [15:0]            descriptor_status_word,
   output logic      [1:0]             loopback_mode
);
   typedef enum logic [2:0]
   {
      RPF_IDLE_S   = 3'b001,
      RPF_SEARCH_S = 3'b010,
      RPF_DECIDE_S = 3'b100
   } rpf_state_type;

   logic          rst_meta_reg;
   logic          rst_sync_reg;
   logic          crs_a_reg;
   logic          crs_b_reg;
   logic          crs_c_reg;
   logic          carrier_reg;
   rpf_ctrl_type  ctrl_reg;
   logic [8:0]    stat_reg;
   rpf_state_type state_reg;
   logic [IDX_W:0] idx_reg;
   logic          hit_reg;
   rpf_pkt_type   pkt_reg;
   logic [48:0]   rd_entry;
   logic [15:0]   accept_count_reg;
   logic          soft_seen_reg;
   logic          is_group;
   logic          is_bcast;
   logic          decide;

   // Group bit test, used for several decisions
   function automatic logic group_addr(input logic [47:0] a);
      group_addr = a[40];
   endfunction : group_addr

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Carrier pin through three flops, then a fourth loaded only when the last two agree
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         crs_a_reg   <= 1'b0;
         crs_b_reg   <= 1'b0;
         crs_c_reg   <= 1'b0;
         carrier_reg <= 1'b0;
      end
      else
      begin
         crs_a_reg <= carrier_pin;
         crs_b_reg <= crs_a_reg;
         crs_c_reg <= crs_b_reg;
         if (crs_b_reg == crs_c_reg)
            carrier_reg <= crs_c_reg;
      end
   end

   // Address table
   rpf_match_mem #(
      .DEPTH   (DEPTH),
      .IDX_W   (IDX_W)
   ) u_table (
      .clk     (clk),
      .wr_en   (tbl_wr),
      .wr_idx  (tbl_idx),
      .wr_data (tbl_data),
      .rd_idx  (idx_reg[IDX_W-1:0]),
      .rd_data (rd_entry)
   );

   // Destination class
   assign is_group = group_addr(pkt_reg.dest);
   assign is_bcast = &pkt_reg.dest;

   // Control bits: software writable, hardware reset only
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         ctrl_reg <= `RPF_CTRL_RESET;
      else if (reg_wr && reg_addr == `RPF_OFS_FILT_STAT)
         ctrl_reg <= reg_wdata[`RPF_CTRL_HI:`RPF_CTRL_LO];
   end

   // Soft reset ignored by this register; only noted
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         soft_seen_reg <= 1'b0;
      else if (soft_reset)
         soft_seen_reg <= 1'b1;
      else if (reg_wr && reg_addr == `RPF_OFS_LIVE)
         soft_seen_reg <= 1'b0;
   end

   // Packet search sequencer
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         state_reg <= RPF_IDLE_S;
         idx_reg   <= '0;
         hit_reg   <= 1'b0;
         pkt_reg   <= '0;
      end
      else
      begin
         unique case (state_reg)
            RPF_IDLE_S:
               if (pkt_end)
               begin
                  pkt_reg   <= pkt_info;
                  idx_reg   <= '0;
                  hit_reg   <= 1'b0;
                  state_reg <= RPF_SEARCH_S;
               end
            RPF_SEARCH_S:
            begin
               // Entry read lags index by one cycle
               if (idx_reg != '0 && rd_entry[48] && rd_entry[47:0] == pkt_reg.dest)
                  hit_reg <= 1'b1;
               if (idx_reg == (IDX_W+1)'(DEPTH))
                  state_reg <= RPF_DECIDE_S;
               else
                  idx_reg <= idx_reg + 1'b1;
            end
            RPF_DECIDE_S:
               state_reg <= RPF_IDLE_S;
            default:
               state_reg <= RPF_IDLE_S;
         endcase
      end
   end

   // Entry zero, read again after the index wraps, folds into decision
   logic table_hit;
   assign table_hit = hit_reg ||
      (rd_entry[48] && rd_entry[47:0] == pkt_reg.dest);

   // Acceptance decision
   always_comb
   begin
      decide = table_hit;
      if (ctrl_reg.promiscuous_enable && !is_group)
         decide = 1'b1;
      if (ctrl_reg.accept_all_group && is_group)
         decide = 1'b1;
      if (ctrl_reg.accept_broadcast && is_bcast)
         decide = 1'b1;
      if (pkt_reg.length < `RPF_MIN_LEN && !ctrl_reg.accept_short_packets)
         decide = 1'b0;
      if ((pkt_reg.crc_err || pkt_reg.collision) && !ctrl_reg.accept_errors)
         decide = 1'b0;
   end

   // Status bits: bit 5 follows carrier; others set on accepted decision, all but bit 4 cleared at next start
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         stat_reg <= `RPF_STAT_RESET;
      else
      begin
         stat_reg[5] <= carrier_reg;
         if (state_reg == RPF_DECIDE_S && decide)
         begin
            stat_reg[8] <= is_group && !is_bcast;
            stat_reg[7] <= is_bcast;
            stat_reg[6] <= pkt_reg.last_in_area;
            stat_reg[4] <= pkt_reg.collision;
            stat_reg[3] <= pkt_reg.crc_err && !pkt_reg.align_err;
            stat_reg[2] <= pkt_reg.align_err;
            stat_reg[1] <= pkt_reg.looped;
            stat_reg[0] <= !pkt_reg.crc_err && !pkt_reg.align_err && !pkt_reg.collision;
         end
         else if (pkt_start)
         begin
            stat_reg[8:6] <= 3'h0;
            stat_reg[3:0] <= 4'h0;
         end
      end
   end

   // Result strobes and descriptor word
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         pkt_accept             <= 1'b0;
         pkt_reject             <= 1'b0;
         descriptor_status_word <= 16'h0000;
         accept_count_reg       <= 16'h0000;
      end
      else
      begin
         pkt_accept <= 1'b0;
         pkt_reject <= 1'b0;
         if (state_reg == RPF_DECIDE_S)
         begin
            pkt_accept <= decide;
            pkt_reject <= !decide;
            if (decide)
               accept_count_reg <= accept_count_reg + 16'h0001;
         end
         if (pkt_accept)
            descriptor_status_word <= {ctrl_reg, stat_reg};
      end
   end

   // Loopback mode output
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         loopback_mode <= `RPF_LB_NORMAL;
      else
         loopback_mode <= ctrl_reg.loop_sel;
   end

   // Register read, one cycle later; status read-only
   always_ff @(posedge clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `RPF_OFS_FILT_STAT: reg_rdata <= {ctrl_reg, stat_reg};
            `RPF_OFS_LIVE:      reg_rdata <= {13'h0000, soft_seen_reg, carrier_reg,
                                              state_reg != RPF_IDLE_S};
            `RPF_OFS_COUNT:     reg_rdata <= accept_count_reg;
            default:            reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

   // Assertions
   a_hw_reset_clear: assert property (@(posedge clk)
      $rose(rst_sync_reg) |-> ctrl_reg == '0)
      else $error("control not clear after reset");
   a_ctrl_written: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      reg_wr && reg_addr == `RPF_OFS_FILT_STAT |=> ctrl_reg == $past(reg_wdata[15:9]))
      else $error("control write lost");
   a_start_clears: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      pkt_start && state_reg != RPF_DECIDE_S |=> stat_reg[3:0] == 4'h0 && stat_reg[8:6] == 3'h0)
      else $error("status not cleared at start");
   a_soft_keeps: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      soft_reset && !reg_wr |=> $stable(ctrl_reg))
      else $error("soft reset changed control");
   a_err_reject: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      state_reg == RPF_DECIDE_S && pkt_reg.crc_err && !ctrl_reg.accept_errors
      |=> pkt_reject && !pkt_accept)
      else $error("error packet accepted");
   a_short_reject: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      state_reg == RPF_DECIDE_S && pkt_reg.length < `RPF_MIN_LEN
      && !ctrl_reg.accept_short_packets |=> pkt_reject)
      else $error("short packet accepted");
   a_bcast_group: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      state_reg == RPF_DECIDE_S && is_bcast && ctrl_reg.accept_all_group
      && !pkt_reg.crc_err && !pkt_reg.collision && pkt_reg.length >= `RPF_MIN_LEN
      |=> pkt_accept)
      else $error("broadcast dropped in all-group mode");
   a_align_wins: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      state_reg == RPF_DECIDE_S && decide && pkt_reg.align_err |=> !stat_reg[3] && stat_reg[2])
      else $error("crc flag set with alignment error");
   a_desc_copy: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      pkt_accept |=> descriptor_status_word == $past({ctrl_reg, stat_reg}))
      else $error("descriptor word mismatch");
   a_search_bound: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      state_reg == RPF_IDLE_S && pkt_end |-> ##[2:40] (pkt_accept || pkt_reject))
      else $error("no decision after packet end");

   c_accept: cover property (@(posedge clk) pkt_accept);
   c_reject: cover property (@(posedge clk) pkt_reject);
   c_promisc: cover property (@(posedge clk) pkt_accept && ctrl_reg.promiscuous_enable);
   c_loop: cover property (@(posedge clk) loopback_mode == `RPF_LB_XCVR);
endmodule : rpf_filter
`default_nettype wire

/* rtl/rpf_map.svh */
// Purpose: Register offsets, field positions and reset values of the receive filter block
// Assumes: 16-bit register data over a plain strobe port
// Notes:   Included by bare name
`ifndef RPF_MAP_SVH
`define RPF_MAP_SVH
`define RPF_ADDR_W          6
`define RPF_OFS_FILT_STAT   6'h02
`define RPF_OFS_LIVE        6'h03
`define RPF_OFS_COUNT       6'h04
`define RPF_BIT_ERR         15
`define RPF_BIT_RNT         14
`define RPF_BIT_BRD         13
`define RPF_BIT_PRO         12
`define RPF_BIT_AMC         11
`define RPF_CTRL_HI         15
`define RPF_CTRL_LO         9
`define RPF_CTRL_RESET      7'h00
`define RPF_STAT_RESET      9'h000
`define RPF_MIN_LEN         12'h040
`define RPF_TABLE_DEPTH     16
`define RPF_TABLE_IDX_W     4
`define RPF_LB_NORMAL       2'h0
`define RPF_LB_MAC          2'h1
`define RPF_LB_CODER        2'h2
`define RPF_LB_XCVR         2'h3
`endif

/* rtl/rpf_pkg.sv */
// Purpose: Types shared by the receive filter block
// Assumes: Nothing beyond the map header
// Notes:   Constants live in rpf_map.svh
package rpf_pkg;
   // Loopback selection
   typedef enum logic [1:0]
   {
      RPF_LB_NONE_E  = 2'h0,
      RPF_LB_MAC_E   = 2'h1,
      RPF_LB_CODER_E = 2'h2,
      RPF_LB_XCVR_E  = 2'h3
   } rpf_loop_type;

   // One packet summary from the receive path
   typedef struct packed
   {
      logic [47:0] dest;
      logic [11:0] length;
      logic        crc_err;
      logic        align_err;
      logic        collision;
      logic        last_in_area;
      logic        looped;
   } rpf_pkt_type;

   // Software control fields
   typedef struct packed
   {
      logic         accept_errors;
      logic         accept_short_packets;
      logic         accept_broadcast;
      logic         promiscuous_enable;
      logic         accept_all_group;
      rpf_loop_type loop_sel;
   } rpf_ctrl_type;
endpackage : rpf_pkg

/* rtl/rpf_match_mem.sv */
// Purpose: Address match table storage, registered read
// Assumes: One write port, one read port, same clock
// Notes:   Entries are 48-bit addresses with a valid bit
`timescale 1ns/1ps
`default_nettype none
module rpf_match_mem #(
   parameter int DEPTH = 16,
   parameter int IDX_W = 4
)(
   // Clock
   input  wire logic             clk,
   // Write side
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [48:0]      wr_data,
   // Read side
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [48:0]      rd_data
);
   logic [48:0] mem_reg [DEPTH];

   // Storage write
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem_reg[wr_idx] <= wr_data;
   end

   // Registered read
   always_ff @(posedge clk)
   begin
      rd_data <= mem_reg[rd_idx];
   end
endmodule : rpf_match_mem
`default_nettype wire

/* test/rpf_net_model.sv */
// Purpose: Network side source of received packet summaries
// Assumes: Bench calls the tasks; signals change just after a rising edge
// Notes:   Summary lines carry an inverted pattern while not valid
`timescale 1ns/1ps
`default_nettype none
module rpf_net_model
   import rpf_pkg::*;
(
   // Clock
   input  wire logic    clk,
   // Receive path
   output logic         pkt_start,
   output logic         pkt_end,
   output rpf_pkt_type  pkt_info,
   output logic         carrier_pin
);
   // Idle levels at time zero
   initial
   begin
      pkt_start   = 1'b0;
      pkt_end     = 1'b0;
      pkt_info    = '1;
      carrier_pin = 1'b0;
   end

   // Whole frame: start, carrier over the body, end strobe with summary
   task automatic send(input rpf_pkt_type info);
   begin
      @(posedge clk);
      pkt_start   <= 1'b1;
      carrier_pin <= 1'b1;
      @(posedge clk);
      pkt_start <= 1'b0;
      repeat (4) @(posedge clk);
      pkt_end  <= 1'b1;
      pkt_info <= info;
      @(posedge clk);
      pkt_end     <= 1'b0;
      pkt_info    <= ~info; // Stale summary is not shown
      carrier_pin <= 1'b0;
   end
   endtask : send

   // Start strobe alone, to probe what a new frame clears
   task automatic start_only;
   begin
      @(posedge clk);
      pkt_start <= 1'b1;
      @(posedge clk);
      pkt_start <= 1'b0;
   end
   endtask : start_only
endmodule : rpf_net_model
`default_nettype wire

/* test/rpf_filter_test.sv */
// Purpose: Self-checking bench for the receive filter and status register
// Assumes: Design defaults for table depth; 50 MHz clock
// Notes:   Packet cases are a table of calls with expected outcomes
`timescale 1ns/1ps
`default_nettype none
`include "rpf_map.svh"
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module rpf_filter_test;
   import rpf_pkg::*;
   // Design signals
   logic              clk, rst_n, soft_reset, reg_wr, reg_rd, tbl_wr;
   logic [5:0]        reg_addr;
   logic [15:0]       reg_wdata, reg_rdata, descriptor_status_word;
   logic [3:0]        tbl_idx;
   logic [48:0]       tbl_data;
   logic              pkt_start, pkt_end, carrier_pin, pkt_accept, pkt_reject;
   rpf_pkt_type       pkt_info;
   logic [1:0]        loopback_mode;
   int                err_total, comparisons, i;
   localparam logic [47:0] ADR_A = 48'h0000_1111_2222; // In the table
   localparam logic [47:0] ADR_U = 48'h0200_0000_0009; // Individual, not in table
   localparam logic [47:0] ADR_M = 48'h0100_0000_0005; // Group address
   localparam logic [47:0] ADR_B = 48'hFFFF_FFFF_FFFF; // Broadcast

   rpf_filter rpf_filter_inst (.clk, .rst_n, .soft_reset, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .tbl_wr, .tbl_idx, .tbl_data, .pkt_start, .pkt_end, .pkt_info,
      .carrier_pin, .pkt_accept, .pkt_reject, .descriptor_status_word, .loopback_mode);
   rpf_net_model rpf_net_model_inst (.clk, .pkt_start, .pkt_end, .pkt_info, .carrier_pin);

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end

   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
   begin
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   end
   endtask : check

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
   begin
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   end
   endtask : wr

   // Read, then compare in the single cycle the data stands
   task automatic rchk(input logic [5:0] a, input logic [15:0] e);
   begin
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata);
   end
   endtask : rchk

   // One packet under a given control word, with expected verdict and status
   task automatic run_case(input logic [15:0] ctrl, input logic [47:0] dest,
      input logic [11:0] len, input logic [4:0] fl, input logic acc, input logic [15:0] st);
      int n;
   begin
      wr(`RPF_OFS_FILT_STAT, ctrl);
      rpf_net_model_inst.send('{dest, len, fl[4], fl[3], fl[2], fl[1], fl[0]});
      #1;
      for (n = 0; n < 40 && pkt_accept !== 1'b1 && pkt_reject !== 1'b1; n++)
         @(posedge clk) #1;
      if (n == 40)
      begin
         err_total++;
         print_verdict();
      end
      `CHK("pkt_accept", acc, pkt_accept);
      `CHK("pkt_reject", !acc, pkt_reject);
      if (acc)
      begin
         @(posedge clk) #1;
         `CHK("descriptor", {ctrl[15:9], st[8:0]}, descriptor_status_word);
         rchk(`RPF_OFS_FILT_STAT, {ctrl[15:9], st[8:0]});
      end
   end
   endtask : run_case

   task automatic print_verdict;
   begin
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask : print_verdict

   // Main sequence
   initial
   begin
      err_total   = 0;
      comparisons = 0;
      rst_n       = 1'b0;
      soft_reset  = 1'b0;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_addr    = 6'h00;
      reg_wdata   = 16'h0000;
      tbl_wr      = 1'b0;
      tbl_idx     = 4'h0;
      tbl_data    = 49'h0_0000_0000_0000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(`RPF_OFS_FILT_STAT, 16'h0000);
      `CHK("loopback_mode", 2'h0, loopback_mode);
      rchk(6'h3F, 16'h0000);
      wr(6'h3F, 16'hFFFF);
      wr(`RPF_OFS_FILT_STAT, 16'hFFFF);
      rchk(`RPF_OFS_FILT_STAT, 16'hFE00);
      for (i = 0; i < 4; i++)
      begin
         wr(`RPF_OFS_FILT_STAT, 16'(i) << 9);
         repeat (2) @(posedge clk);
         #1;
         `CHK("loopback_mode", i, loopback_mode);
      end
      // Table: entry zero holds the station address, the rest empty
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         tbl_wr   <= 1'b1;
         tbl_idx  <= 4'(i);
         tbl_data <= (i == 0) ? {1'b1, ADR_A} : 49'h0_0000_0000_0000;
      end
      @(posedge clk);
      tbl_wr <= 1'b0;
      // Flags are crc, align, collision, last in area, looped
      run_case(16'h0000, ADR_A, 12'h064, 5'h00, 1'b1, 16'h0001);
      run_case(16'h0000, ADR_U, 12'h064, 5'h00, 1'b0, 16'h0000);
      run_case(16'h1000, ADR_U, 12'h064, 5'h00, 1'b1, 16'h0001);
      run_case(16'h1000, ADR_M, 12'h064, 5'h00, 1'b0, 16'h0000);
      run_case(16'h0800, ADR_M, 12'h064, 5'h00, 1'b1, 16'h0101);
      run_case(16'h0800, ADR_B, 12'h064, 5'h00, 1'b1, 16'h0081);
      run_case(16'h0000, ADR_B, 12'h064, 5'h00, 1'b0, 16'h0000);
      run_case(16'h2000, ADR_B, 12'h064, 5'h00, 1'b1, 16'h0081);
      run_case(16'h2000, ADR_A, 12'h064, 5'h00, 1'b1, 16'h0001);
      run_case(16'h0000, ADR_A, 12'h03F, 5'h00, 1'b0, 16'h0000);
      run_case(16'h0000, ADR_A, 12'h040, 5'h00, 1'b1, 16'h0001);
      run_case(16'h4000, ADR_A, 12'h03F, 5'h00, 1'b1, 16'h0001);
      run_case(16'h0000, ADR_A, 12'h064, 5'h10, 1'b0, 16'h0000);
      run_case(16'h8000, ADR_A, 12'h064, 5'h10, 1'b1, 16'h0008);
      run_case(16'h8000, ADR_A, 12'h064, 5'h18, 1'b1, 16'h0004);
      run_case(16'h0000, ADR_A, 12'h064, 5'h04, 1'b0, 16'h0000);
      run_case(16'h0200, ADR_A, 12'h064, 5'h03, 1'b1, 16'h0043);
      run_case(16'h8200, ADR_A, 12'h064, 5'h07, 1'b1, 16'h0052);
      // New frame start clears all status but collision and carrier
      rpf_net_model_inst.start_only();
      repeat (2) @(posedge clk);
      rchk(`RPF_OFS_FILT_STAT, 16'h8210);
      @(posedge clk);
      soft_reset <= 1'b1;
      repeat (2) @(posedge clk);
      soft_reset <= 1'b0;
      rchk(`RPF_OFS_FILT_STAT, 16'h8210);
      // Live word shows the noted soft reset; twelve packets were accepted
      rchk(`RPF_OFS_LIVE, 16'h0004);
      rchk(`RPF_OFS_COUNT, 16'h000C);
      // Mid-run hardware reset must clear the control bits again
      wr(`RPF_OFS_FILT_STAT, 16'h7E00);
      rchk(`RPF_OFS_FILT_STAT, 16'h7E10);
      repeat (2) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(`RPF_OFS_FILT_STAT, 16'h0000);
      `CHK("loopback_mode", 2'h0, loopback_mode);
      print_verdict();
   end
endmodule : rpf_filter_test
`default_nettype wire
